/* File: design/fxtr_defs.vh */
// Constants shared by the fixed-point trap, rotate and special-register datapath.
// Assumes inclusion by bare name from files in the same folder.
`ifndef FXTR_DEFS_VH
`define FXTR_DEFS_VH

// ============================================================
// Operation codes from the instruction decoder
`define FXTR_OP_W 4
`define FXTR_OP_NOP 4'h0
`define FXTR_OP_TRAP 4'h1
`define FXTR_OP_LOGIC 4'h2
`define FXTR_OP_ROT_INSERT 4'h3
`define FXTR_OP_ROT_MASK 4'h4
`define FXTR_OP_ROT_RIGHT 4'h5
`define FXTR_OP_SHIFT_LEFT 4'h6
`define FXTR_OP_SHIFT_RIGHT 4'h7
`define FXTR_OP_SHIFT_LEFT_MQ 4'h8
`define FXTR_OP_SHIFT_RIGHT_MQ 4'h9
`define FXTR_OP_SPR_TO_GPR 4'hA
`define FXTR_OP_GPR_TO_SPR 4'hB
`define FXTR_OP_SPR_TO_SPR 4'hC

// ============================================================
// Logical functions
`define FXTR_LF_AND 3'h0
`define FXTR_LF_OR 3'h1
`define FXTR_LF_XOR 3'h2
`define FXTR_LF_NAND 3'h3
`define FXTR_LF_NOR 3'h4
`define FXTR_LF_EQV 3'h5
`define FXTR_LF_ANDC 3'h6
`define FXTR_LF_ORC 3'h7

// ============================================================
// Trap condition positions within the five-bit mask
`define FXTR_TC_W 5
`define FXTR_TC_LT 0
`define FXTR_TC_GT 1
`define FXTR_TC_EQ 2
`define FXTR_TC_LLT 3
`define FXTR_TC_LGT 4

// ============================================================
// Special-register numbering
`define FXTR_SPR_W 10
`define FXTR_SPR_HALF 5
`define FXTR_SPR_PRIV_BIT 4
`define FXTR_DEC_NEW 10'h016
`define FXTR_DEC_LEGACY 10'h006

// ============================================================
// Register port: byte offsets, field positions, reset values
`define FXTR_ADDR_W 5
`define FXTR_REG_CTRL 5'h00
`define FXTR_REG_STATUS 5'h04
`define FXTR_REG_IRQ_EN 5'h08
`define FXTR_REG_IRQ_CLR 5'h0C
`define FXTR_REG_MQ 5'h10
`define FXTR_CTRL_LEGACY 0
`define FXTR_EV_W 3
`define FXTR_EV_TRAP 0
`define FXTR_EV_PRIV 1
`define FXTR_EV_DEC 2
`define FXTR_CTRL_RST 1'h0
`define FXTR_IRQ_EN_RST 3'h0
`define FXTR_MQ_RST 32'h00000000

`endif

/* File: design/fxtr_rotmask.v */
// Left rotator with mask generator and insert or replace merge.
// Assumes big-endian bit numbering for mask bounds: position 0 is the MSB.
`timescale 1ns/1ps
`include "fxtr_defs.vh"

module fxtr_rotmask #(
  parameter WIDTH = 32,
  parameter AMT_W = 5
) (
  input wire [WIDTH-1:0] rot_in,
  input wire [AMT_W-1:0] rot_amt,
  input wire [AMT_W-1:0] mask_begin,
  input wire [AMT_W-1:0] mask_end,
  input wire use_ext_mask,
  input wire [WIDTH-1:0] ext_mask,
  input wire insert,
  input wire [WIDTH-1:0] target_old,
  output wire [WIDTH-1:0] rotated,
  output wire [WIDTH-1:0] result
);
  // ============================================================
  // Rotation, left only
  wire [2*WIDTH-1:0] doubled;
  wire [2*WIDTH-1:0] shifted;
  wire [WIDTH-1:0] gen_mask;
  wire [WIDTH-1:0] mask;

  assign doubled = {rot_in, rot_in};
  assign shifted = doubled << rot_amt;
  assign rotated = shifted[2*WIDTH-1:WIDTH];

  // ============================================================
  // Mask generation and merge per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      localparam integer POS_I = WIDTH - 1 - i;
      localparam [AMT_W-1:0] POS = POS_I[AMT_W-1:0];
      // A begin past the end wraps around the word
      assign gen_mask[i] = (mask_begin <= mask_end) ?
                           ((POS >= mask_begin) && (POS <= mask_end)) :
                           ((POS >= mask_begin) || (POS <= mask_end));
      assign mask[i] = use_ext_mask ? ext_mask[i] : gen_mask[i];
      assign result[i] = mask[i] ? rotated[i] : (insert & target_old[i]);
    end
  endgenerate
endmodule

/* File: design/fxtr_spr_decode.v */
// Special-register number field decoder.
// Assumes the field arrives as printed in the instruction, halves swapped.
`timescale 1ns/1ps
`include "fxtr_defs.vh"

module fxtr_spr_decode (
  input wire [`FXTR_SPR_W-1:0] spr_field,
  input wire legacy,
  output wire [`FXTR_SPR_W-1:0] spr_num,
  output wire privileged,
  output wire is_decrementer
);
  // ============================================================
  // Number recovery
  wire [`FXTR_SPR_W-1:0] swapped_num;
  wire [`FXTR_SPR_W-1:0] legacy_num;

  assign swapped_num = {spr_field[`FXTR_SPR_HALF-1:0],
                        spr_field[`FXTR_SPR_W-1:`FXTR_SPR_HALF]};
  // The legacy field is only five bits; it sits where the low half lands
  assign legacy_num = {{`FXTR_SPR_HALF{1'b0}}, spr_field[`FXTR_SPR_W-1:`FXTR_SPR_HALF]};
  assign spr_num = legacy ? legacy_num : swapped_num;

  // ============================================================
  // Attributes
  assign privileged = spr_num[`FXTR_SPR_PRIV_BIT];
  assign is_decrementer = legacy ? (spr_num == `FXTR_DEC_LEGACY) :
                          (spr_num == `FXTR_DEC_NEW);
endmodule

/* File: design/fxtr_datapath.v */
// Fixed-point trap, logical, rotate/shift and special-register move slice.
// Assumes one issue per cycle from the decoder, results one cycle later.
//
// Contract
// - Signed flags: position 0 less than, 1 greater than, 2 equal.
// - Unsigned flags: logically less than and logically greater than.
// - Flags ANDed with the condition mask; any set bit raises a trap.
// - First source compares with sign-extended immediate or second source, low 32 bits.
// - Logical operations work bit by bit with no carries.
// - Rotate-insert: mask 1 takes rotated bit, mask 0 keeps old target bit.
// - Rotate-mask: rotated value ANDed with mask replaces whole target.
// - Only left rotation; right by n is left by 32 minus n.
// - Logical left and right shifts written under a generated mask.
// - Legacy variant shifts with the quotient register also update it.
// - Moves special to special, special to general, general to special.
// - Special number field is 10 bits newer, 5 bits legacy.
// - The 10-bit field holds two 5-bit halves swapped.
// - One number bit marks privileged access when set.
// - Decrementer is number 22 privileged newer, 6 nonprivileged legacy.
`timescale 1ns/1ps
`include "fxtr_defs.vh"

module fxtr_datapath #(
  parameter WIDTH = 32
) (
  input wire ref_clk,
  input wire rst,
  input wire op_valid,
  input wire [`FXTR_OP_W-1:0] op_code,
  input wire [2:0] logic_func,
  input wire [WIDTH-1:0] first_source_register,
  input wire [WIDTH-1:0] second_source_register,
  input wire [WIDTH-1:0] target_old,
  input wire [15:0] imm16,
  input wire use_imm,
  input wire [`FXTR_TC_W-1:0] trap_condition_mask,
  input wire [4:0] rot_amount,
  input wire [4:0] mask_begin,
  input wire [4:0] mask_end,
  input wire [5:0] shift_amount,
  input wire [`FXTR_SPR_W-1:0] spr_src_field,
  input wire [`FXTR_SPR_W-1:0] spr_dst_field,
  input wire user_mode,
  output wire [`FXTR_SPR_W-1:0] spr_rd_num,
  input wire [WIDTH-1:0] spr_rd_data,
  output reg res_valid,
  output reg gpr_wr_en,
  output reg [WIDTH-1:0] gpr_wr_data,
  output reg spr_wr_en,
  output reg [`FXTR_SPR_W-1:0] spr_wr_num,
  output reg [WIDTH-1:0] spr_wr_data,
  output reg trap_req,
  output reg priv_fault,
  output reg dec_access,
  input wire [`FXTR_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wr_data,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rd_data,
  output wire irq
);
  // ============================================================
  // Control and status state
  reg legacy;
  reg [`FXTR_EV_W-1:0] ev_status;
  reg [`FXTR_EV_W-1:0] irq_en;
  reg [WIDTH-1:0] multiply_quotient_register;

  // ============================================================
  // Trap comparison
  wire [WIDTH-1:0] trap_b;
  wire [`FXTR_TC_W-1:0] trap_flags;
  wire trap_hit;

  assign trap_b = use_imm ? {{(WIDTH-16){imm16[15]}}, imm16} : second_source_register;
  assign trap_flags[`FXTR_TC_LT] = $signed(first_source_register) < $signed(trap_b);
  assign trap_flags[`FXTR_TC_GT] = $signed(first_source_register) > $signed(trap_b);
  assign trap_flags[`FXTR_TC_EQ] = first_source_register == trap_b;
  assign trap_flags[`FXTR_TC_LLT] = first_source_register < trap_b;
  assign trap_flags[`FXTR_TC_LGT] = first_source_register > trap_b;
  assign trap_hit = |(trap_flags & trap_condition_mask);

  // ============================================================
  // Logical unit
  reg [WIDTH-1:0] logic_res;

  always @* begin
    case (logic_func)
      `FXTR_LF_AND: logic_res = first_source_register & second_source_register;
      `FXTR_LF_OR: logic_res = first_source_register | second_source_register;
      `FXTR_LF_XOR: logic_res = first_source_register ^ second_source_register;
      `FXTR_LF_NAND: logic_res = ~(first_source_register & second_source_register);
      `FXTR_LF_NOR: logic_res = ~(first_source_register | second_source_register);
      `FXTR_LF_EQV: logic_res = ~(first_source_register ^ second_source_register);
      `FXTR_LF_ANDC: logic_res = first_source_register & ~second_source_register;
      `FXTR_LF_ORC: logic_res = first_source_register | ~second_source_register;
      default: logic_res = {WIDTH{1'b0}};
    endcase
  end

  // ============================================================
  // Rotate and shift control
  wire is_left_shift;
  wire is_right_shift;
  wire is_shift;
  wire [5:0] right_rot;
  wire [5:0] right_shift_rot;
  reg [4:0] rot_amt;
  wire [WIDTH-1:0] shift_mask;
  wire [WIDTH-1:0] rotated;
  wire [WIDTH-1:0] rot_result;

  assign is_left_shift = (op_code == `FXTR_OP_SHIFT_LEFT) ||
                         (op_code == `FXTR_OP_SHIFT_LEFT_MQ);
  assign is_right_shift = (op_code == `FXTR_OP_SHIFT_RIGHT) ||
                          (op_code == `FXTR_OP_SHIFT_RIGHT_MQ);
  assign is_shift = is_left_shift | is_right_shift;
  assign right_rot = 6'h20 - {1'b0, rot_amount};
  assign right_shift_rot = 6'h20 - {1'b0, shift_amount[4:0]};
  // Shift counts of 32 and above clear the whole word
  assign shift_mask = shift_amount[5] ? {WIDTH{1'b0}} :
                      (is_left_shift ? ({WIDTH{1'b1}} << shift_amount[4:0]) :
                      ({WIDTH{1'b1}} >> shift_amount[4:0]));

  always @* begin
    if (op_code == `FXTR_OP_ROT_RIGHT) begin
      rot_amt = right_rot[4:0];
    end else if (is_right_shift) begin
      rot_amt = right_shift_rot[4:0];
    end else if (is_left_shift) begin
      rot_amt = shift_amount[4:0];
    end else begin
      rot_amt = rot_amount;
    end
  end

  fxtr_rotmask #(
    .WIDTH(WIDTH),
    .AMT_W(5)
  ) u_rotmask (
    .rot_in(first_source_register),
    .rot_amt(rot_amt),
    .mask_begin(mask_begin),
    .mask_end(mask_end),
    .use_ext_mask(is_shift),
    .ext_mask(shift_mask),
    .insert(op_code == `FXTR_OP_ROT_INSERT),
    .target_old(target_old),
    .rotated(rotated),
    .result(rot_result)
  );

  // ============================================================
  // Special-register decode
  wire [`FXTR_SPR_W-1:0] src_num;
  wire src_priv;
  wire src_dec;
  wire [`FXTR_SPR_W-1:0] dst_num;
  wire dst_priv;

  fxtr_spr_decode u_spr_src (
    .spr_field(spr_src_field),
    .legacy(legacy),
    .spr_num(src_num),
    .privileged(src_priv),
    .is_decrementer(src_dec)
  );

  fxtr_spr_decode u_spr_dst (
    .spr_field(spr_dst_field),
    .legacy(legacy),
    .spr_num(dst_num),
    .privileged(dst_priv),
    .is_decrementer()
  );

  // Read port address is combinational so the file answers in the issue cycle
  assign spr_rd_num = src_num;

  // ============================================================
  // Result selection
  reg next_gpr_wr_en;
  reg [WIDTH-1:0] next_gpr_wr_data;
  reg next_spr_wr_en;
  reg [WIDTH-1:0] next_spr_wr_data;
  reg next_trap;
  reg next_priv;
  reg next_dec;
  reg next_mq_wr;

  always @* begin
    next_gpr_wr_en = 1'b0;
    next_gpr_wr_data = {WIDTH{1'b0}};
    next_spr_wr_en = 1'b0;
    next_spr_wr_data = {WIDTH{1'b0}};
    next_trap = 1'b0;
    next_priv = 1'b0;
    next_dec = 1'b0;
    next_mq_wr = 1'b0;
    if (op_valid) begin
      case (op_code)
        `FXTR_OP_TRAP: begin
          next_trap = trap_hit;
        end
        `FXTR_OP_LOGIC: begin
          next_gpr_wr_en = 1'b1;
          next_gpr_wr_data = logic_res;
        end
        `FXTR_OP_ROT_INSERT, `FXTR_OP_ROT_MASK, `FXTR_OP_ROT_RIGHT: begin
          next_gpr_wr_en = 1'b1;
          next_gpr_wr_data = rot_result;
        end
        `FXTR_OP_SHIFT_LEFT, `FXTR_OP_SHIFT_RIGHT: begin
          next_gpr_wr_en = 1'b1;
          next_gpr_wr_data = rot_result;
        end
        `FXTR_OP_SHIFT_LEFT_MQ, `FXTR_OP_SHIFT_RIGHT_MQ: begin
          next_gpr_wr_en = 1'b1;
          next_gpr_wr_data = rot_result;
          // Newer variant has no quotient register; these act as plain shifts
          next_mq_wr = legacy;
        end
        `FXTR_OP_SPR_TO_GPR: begin
          next_priv = src_priv & user_mode;
          next_dec = src_dec;
          next_gpr_wr_en = ~next_priv;
          next_gpr_wr_data = spr_rd_data;
        end
        `FXTR_OP_GPR_TO_SPR: begin
          next_priv = dst_priv & user_mode;
          next_spr_wr_en = ~next_priv;
          next_spr_wr_data = first_source_register;
        end
        `FXTR_OP_SPR_TO_SPR: begin
          next_priv = (src_priv | dst_priv) & user_mode;
          next_dec = src_dec;
          next_spr_wr_en = ~next_priv;
          next_spr_wr_data = spr_rd_data;
        end
        default: begin
          next_gpr_wr_en = 1'b0;
        end
      endcase
    end
    if (next_trap) begin
      next_gpr_wr_en = 1'b0;
      next_spr_wr_en = 1'b0;
    end
  end

  // ============================================================
  // Result stage
  always @(posedge ref_clk) begin
    if (rst) begin
      res_valid <= 1'b0;
      gpr_wr_en <= 1'b0;
      gpr_wr_data <= {WIDTH{1'b0}};
      spr_wr_en <= 1'b0;
      spr_wr_num <= {`FXTR_SPR_W{1'b0}};
      spr_wr_data <= {WIDTH{1'b0}};
      trap_req <= 1'b0;
      priv_fault <= 1'b0;
      dec_access <= 1'b0;
    end else begin
      res_valid <= op_valid;
      gpr_wr_en <= next_gpr_wr_en;
      gpr_wr_data <= next_gpr_wr_data;
      spr_wr_en <= next_spr_wr_en;
      spr_wr_num <= dst_num;
      spr_wr_data <= next_spr_wr_data;
      trap_req <= next_trap;
      priv_fault <= next_priv;
      dec_access <= next_dec & ~next_priv;
    end
  end

  // ============================================================
  // Register port, events and interrupt
  wire [`FXTR_EV_W-1:0] ev_set;
  wire [`FXTR_EV_W-1:0] ev_clr;
  wire wr_mq;

  assign ev_set = {next_dec & ~next_priv, next_priv, next_trap};
  assign ev_clr = (reg_wr && (reg_addr == `FXTR_REG_IRQ_CLR)) ?
                  reg_wr_data[`FXTR_EV_W-1:0] : {`FXTR_EV_W{1'b0}};
  assign wr_mq = reg_wr && (reg_addr == `FXTR_REG_MQ);
  assign irq = |(ev_status & irq_en);

  always @(posedge ref_clk) begin
    if (rst) begin
      legacy <= `FXTR_CTRL_RST;
      ev_status <= {`FXTR_EV_W{1'b0}};
      irq_en <= `FXTR_IRQ_EN_RST;
      multiply_quotient_register <= `FXTR_MQ_RST;
      reg_rd_data <= 32'h00000000;
    end else begin
      // A new event in the clearing cycle stays set
      ev_status <= (ev_status & ~ev_clr) | ev_set;
      if (reg_wr && (reg_addr == `FXTR_REG_CTRL)) begin
        legacy <= reg_wr_data[`FXTR_CTRL_LEGACY];
      end
      if (reg_wr && (reg_addr == `FXTR_REG_IRQ_EN)) begin
        irq_en <= reg_wr_data[`FXTR_EV_W-1:0];
      end
      // Datapath update wins over a software write in the same cycle
      if (next_mq_wr) begin
        multiply_quotient_register <= rotated;
      end else if (wr_mq) begin
        multiply_quotient_register <= reg_wr_data[WIDTH-1:0];
      end
      if (reg_rd) begin
        case (reg_addr)
          `FXTR_REG_CTRL: reg_rd_data <= {31'h00000000, legacy};
          `FXTR_REG_STATUS: reg_rd_data <= {{(32-`FXTR_EV_W){1'b0}}, ev_status};
          `FXTR_REG_IRQ_EN: reg_rd_data <= {{(32-`FXTR_EV_W){1'b0}}, irq_en};
          `FXTR_REG_MQ: reg_rd_data <= multiply_quotient_register;
          default: reg_rd_data <= 32'h00000000;
        endcase
      end else begin
        reg_rd_data <= 32'h00000000;
      end
    end
  end
endmodule

/* File: sim/fxtr_datapath_props.sv */
// Port-level checker for the trap, rotate and special-register datapath.
// Assumes bind to every fxtr_datapath instance and fxtr_defs.vh on the include path.
`timescale 1ns/1ps
`include "fxtr_defs.vh"

module fxtr_datapath_props (
  input wire ref_clk,
  input wire rst,
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [2:0] logic_func,
  input wire [31:0] first_source_register,
  input wire [31:0] second_source_register,
  input wire [15:0] imm16,
  input wire use_imm,
  input wire [4:0] trap_condition_mask,
  input wire [4:0] rot_amount,
  input wire [4:0] mask_begin,
  input wire [4:0] mask_end,
  input wire [9:0] spr_src_field,
  input wire user_mode,
  input wire [9:0] spr_rd_num,
  input wire [31:0] spr_rd_data,
  input wire res_valid,
  input wire gpr_wr_en,
  input wire [31:0] gpr_wr_data,
  input wire spr_wr_en,
  input wire trap_req,
  input wire priv_fault,
  input wire dec_access,
  input wire [4:0] reg_addr,
  input wire [31:0] reg_wr_data,
  input wire reg_wr
);
  // ============================================================
  // Helper logic
  reg leg;
  wire [31:0] a = first_source_register;
  wire [31:0] b = use_imm ? {{16{imm16[15]}}, imm16} : second_source_register;
  wire [4:0] flg = {a > b, a < b, a == b, $signed(a) > $signed(b), $signed(a) < $signed(b)};
  wire hit = |(flg & trap_condition_mask);
  wire is_mf = op_valid && op_code == `FXTR_OP_SPR_TO_GPR;
  wire [9:0] dec_num = leg ? `FXTR_DEC_LEGACY : `FXTR_DEC_NEW;

  // Shadow of the variant bit; software writes are its only source
  always @(posedge ref_clk) begin
    if (rst) begin
      leg <= 1'b0;
    end else if (reg_wr && reg_addr == `FXTR_REG_CTRL) begin
      leg <= reg_wr_data[0];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ============================================================
  // Properties
  property p_answer;
    op_valid |=> res_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no result one cycle after issue");

  property p_trap;
    trap_req == $past(op_valid && op_code == `FXTR_OP_TRAP && hit);
  endproperty
  a_trap: assert property (p_trap) else $error("trap request wrong");

  property p_trap_wr;
    trap_req |-> !gpr_wr_en && !spr_wr_en;
  endproperty
  a_trap_wr: assert property (p_trap_wr) else $error("write beside trap");

  property p_logic;
    op_valid && op_code == `FXTR_OP_LOGIC && logic_func == `FXTR_LF_AND
      |=> gpr_wr_en && gpr_wr_data == $past(a & second_source_register);
  endproperty
  a_logic: assert property (p_logic) else $error("bitwise and wrong");

  property p_rotr;
    op_valid && op_code == `FXTR_OP_ROT_RIGHT && mask_begin == 5'h00 && mask_end == 5'h1F
      |=> gpr_wr_en && gpr_wr_data == $past(a >> rot_amount | a << (6'h20 - rot_amount));
  endproperty
  a_rotr: assert property (p_rotr) else $error("right rotation wrong");

  property p_num;
    spr_rd_num == (leg ? {5'h00, spr_src_field[9:5]} : {spr_src_field[4:0], spr_src_field[9:5]});
  endproperty
  a_num: assert property (p_num) else $error("special number decode wrong");

  property p_mf;
    is_mf && !(user_mode && spr_rd_num[4]) |=> gpr_wr_en && gpr_wr_data == $past(spr_rd_data);
  endproperty
  a_mf: assert property (p_mf) else $error("move to general wrong");

  property p_priv;
    is_mf && user_mode && spr_rd_num[4] |=> priv_fault && !gpr_wr_en;
  endproperty
  a_priv: assert property (p_priv) else $error("privileged access not refused");

  property p_dec;
    is_mf && spr_rd_num == dec_num && (leg || !user_mode) |=> dec_access && !priv_fault;
  endproperty
  a_dec: assert property (p_dec) else $error("decrementer read not flagged");
endmodule

bind fxtr_datapath fxtr_datapath_props u_props (.ref_clk, .rst, .op_valid, .op_code,
  .logic_func, .first_source_register, .second_source_register, .imm16, .use_imm,
  .trap_condition_mask, .rot_amount, .mask_begin, .mask_end, .spr_src_field, .user_mode,
  .spr_rd_num, .spr_rd_data, .res_valid, .gpr_wr_en, .gpr_wr_data, .spr_wr_en, .trap_req,
  .priv_fault, .dec_access, .reg_addr, .reg_wr_data, .reg_wr);

/* File: sim/fxtr_spr_file_model.sv */
// Special-register file standing behind the datapath's move ports.
// Assumes one clock; reads follow the decoded number in the same cycle.
`timescale 1ns/1ps

module fxtr_spr_file_model (
  input wire ref_clk,
  input wire [9:0] spr_rd_num,
  output wire [31:0] spr_rd_data,
  input wire spr_wr_en,
  input wire [9:0] spr_wr_num,
  input wire [31:0] spr_wr_data
);
  reg [31:0] mem [0:31];
  integer i;
  // Entries carry their index so a misrouted read is visible
  initial begin
    for (i = 0; i < 32; i = i + 1) begin
      mem[i] = 32'h5A000000 | i;
    end
  end
  // Only 32 numbers are held; higher numbers alias by their low bits
  assign spr_rd_data = mem[spr_rd_num[4:0]];
  always @(posedge ref_clk) begin
    if (spr_wr_en) begin
      mem[spr_wr_num[4:0]] <= spr_wr_data;
    end
  end
endmodule

/* File: sim/fxtr_datapath_tb_top.sv */
// Self-checking bench for the datapath, driving decoder and register port.
// Assumes fxtr_defs.vh on the include path and the checker bound in.
`timescale 1ns/1ps
`include "fxtr_defs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module fxtr_datapath_tb_top;
  logic ref_clk, rst, op_valid, use_imm, user_mode, reg_wr, reg_rd;
  logic res_valid, gpr_wr_en, spr_wr_en, trap_req, priv_fault, dec_access, irq;
  logic [3:0] op_code;
  logic [2:0] logic_func;
  logic [15:0] imm16;
  logic [5:0] shift_amount;
  logic [4:0] trap_condition_mask, rot_amount, mask_begin, mask_end, reg_addr;
  logic [9:0] spr_src_field, spr_dst_field, spr_rd_num, spr_wr_num;
  logic [31:0] first_source_register, second_source_register, target_old, reg_wr_data;
  logic [31:0] spr_rd_data, gpr_wr_data, spr_wr_data, reg_rd_data;
  logic [31:0] ta [3] = '{32'hFFFFFFFF, 32'h00000005, 32'h00000007};
  logic [31:0] tb [3] = '{32'h00000001, 32'h00000009, 32'h00000007};
  logic [4:0] tf [3] = '{5'h11, 5'h0A, 5'h04};
  int n_errors = 0;
  int compares = 0;
  int j;
  int k;

  fxtr_datapath #(.WIDTH(32)) uut (.ref_clk, .rst, .op_valid, .op_code, .logic_func,
    .first_source_register, .second_source_register, .target_old, .imm16, .use_imm,
    .trap_condition_mask, .rot_amount, .mask_begin, .mask_end, .shift_amount, .spr_src_field,
    .spr_dst_field, .user_mode, .spr_rd_num, .spr_rd_data, .res_valid, .gpr_wr_en,
    .gpr_wr_data, .spr_wr_en, .spr_wr_num, .spr_wr_data, .trap_req, .priv_fault, .dec_access,
    .reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data, .irq);
  fxtr_spr_file_model u_spr (.ref_clk, .spr_rd_num, .spr_rd_data, .spr_wr_en, .spr_wr_num,
    .spr_wr_data);

  // ============================================================
  // Access tasks
  task automatic go(input logic [3:0] c, input logic [31:0] a, input logic [31:0] b);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= c;
    first_source_register <= a;
    second_source_register <= b;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task automatic run(input logic [3:0] c, input logic [31:0] a, input logic [31:0] e);
    go(c, a, 32'h0F0F00FF);
    `CHK({res_valid, gpr_wr_en, gpr_wr_data}, {2'h3, e})
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rd_data, e)
  endtask
  function automatic logic [31:0] lf(input int f, input logic [31:0] a, input logic [31:0] b);
    case (f)
      0: return a & b;
      1: return a | b;
      2: return a ^ b;
      3: return ~(a & b);
      4: return ~(a | b);
      5: return ~(a ^ b);
      6: return a & ~b;
      default: return a | ~b;
    endcase
  endfunction
  task automatic close_out;
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Guard against a hang anywhere in the sequence
  initial begin
    #100000;
    n_errors++;
    close_out();
  end

  // ============================================================
  // Main sequence
  initial begin
    {rst, op_valid, use_imm, user_mode, reg_wr, reg_rd, op_code, logic_func, imm16} = '0;
    {shift_amount, trap_condition_mask, rot_amount, mask_begin, mask_end, reg_addr} = '0;
    {spr_src_field, spr_dst_field, first_source_register, second_source_register} = '0;
    {target_old, reg_wr_data} = '0;
    rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    wr(5'h14, 32'hFFFFFFFF);
    for (k = 0; k < 6; k++) rd(k[4:0] << 2, 32'h0);
    wr(`FXTR_REG_MQ, 32'hC0DE1234);
    rd(`FXTR_REG_MQ, 32'hC0DE1234);
    wr(`FXTR_REG_MQ, 32'h0);
    for (j = 0; j < 3; j++) begin
      use_imm <= (j == 1);
      imm16 <= 16'hFFFB;
      for (k = 0; k < 6; k++) begin
        trap_condition_mask <= (k == 5) ? 5'h00 : 5'h01 << k;
        go(`FXTR_OP_TRAP, ta[j], tb[j]);
        `CHK({res_valid, trap_req, gpr_wr_en}, {1'b1, k < 5 && tf[j][k], 1'b0})
      end
    end
    rd(`FXTR_REG_STATUS, 32'h1);
    `CHK(irq, 1'b0)
    wr(`FXTR_REG_IRQ_EN, 32'h1);
    `CHK(irq, 1'b1)
    wr(`FXTR_REG_IRQ_CLR, 32'h1);
    `CHK(irq, 1'b0)
    rd(`FXTR_REG_IRQ_EN, 32'h1);
    rd(`FXTR_REG_IRQ_CLR, 32'h0);
    for (k = 0; k < 8; k++) begin
      logic_func <= k[2:0];
      run(`FXTR_OP_LOGIC, 32'hF0F0AA55, lf(k, 32'hF0F0AA55, 32'h0F0F00FF));
    end
    {rot_amount, mask_begin, mask_end} <= {5'd8, 5'd8, 5'd15};
    target_old <= 32'hFFFFFFFF;
    run(`FXTR_OP_ROT_INSERT, 32'h12345678, 32'hFF56FFFF);
    {mask_begin, mask_end} <= {5'd28, 5'd3};
    run(`FXTR_OP_ROT_MASK, 32'h12345678, 32'h30000002);
    {rot_amount, mask_begin, mask_end} <= {5'd4, 5'd0, 5'd31};
    run(`FXTR_OP_ROT_RIGHT, 32'h81234567, 32'h78123456);
    shift_amount <= 6'd4;
    run(`FXTR_OP_SHIFT_LEFT, 32'h12345678, 32'h23456780);
    shift_amount <= 6'd36;
    run(`FXTR_OP_SHIFT_RIGHT, 32'h12345678, 32'h0);
    shift_amount <= 6'd8;
    run(`FXTR_OP_SHIFT_RIGHT, 32'h12345678, 32'h00123456);
    run(`FXTR_OP_SHIFT_LEFT_MQ, 32'h12345678, 32'h34567800);
    rd(`FXTR_REG_MQ, 32'h0);
    wr(`FXTR_REG_CTRL, 32'h1);
    run(`FXTR_OP_SHIFT_RIGHT_MQ, 32'h12345678, 32'h00123456);
    rd(`FXTR_REG_MQ, 32'h78123456);
    user_mode <= 1'b1;
    spr_src_field <= 10'h0C0;
    run(`FXTR_OP_SPR_TO_GPR, 32'h0, 32'h5A000006);
    `CHK({dec_access, priv_fault}, 2'h2)
    wr(`FXTR_REG_CTRL, 32'h0);
    spr_src_field <= 10'h2C0;
    go(`FXTR_OP_SPR_TO_GPR, 32'h0, 32'h0);
    `CHK({priv_fault, gpr_wr_en}, 2'h2)
    user_mode <= 1'b0;
    run(`FXTR_OP_SPR_TO_GPR, 32'h0, 32'h5A000016);
    `CHK(dec_access, 1'b1)
    spr_dst_field <= 10'h020;
    go(`FXTR_OP_GPR_TO_SPR, 32'hDEADBEEF, 32'h0);
    `CHK({spr_wr_en, spr_wr_num, spr_wr_data}, {11'h401, 32'hDEADBEEF})
    {spr_src_field, spr_dst_field} <= {10'h020, 10'h040};
    go(`FXTR_OP_SPR_TO_SPR, 32'h0, 32'h0);
    `CHK({spr_wr_en, spr_wr_num, spr_wr_data}, {11'h402, 32'hDEADBEEF})
    spr_src_field <= 10'h040;
    run(`FXTR_OP_SPR_TO_GPR, 32'h0, 32'hDEADBEEF);
    rd(`FXTR_REG_STATUS, 32'h6);
    `CHK(irq, 1'b0)
    wr(`FXTR_REG_IRQ_CLR, 32'h7);
    rd(`FXTR_REG_STATUS, 32'h0);
    close_out();
  end
endmodule
